// [verilog/general_control_event_regs.sv]
// general control, general-purpose event and input registers with arbiter and query timer
`timescale 1ns/1ns

// Functional notes
// R1: two-bit code picks upstream arbitration policy
// R2: simulation bit shortens card query time
// R3: control bit 12 drives I/O limit bit0
// R4: control bit 11 drives I/O base bit0
// R5: bit 10 selects fitted power switch type
// R6: compliance bit 7 always reads one
// R7: bit 5 disables flash media function
// R8: bit 4 disables second card socket
// R9: reserved control bits read zero
// R10: only global reset clears these bits
// R11: power state change sets status bit 7
// R12: 12 V supply request change sets bit 6
// R13: input pin changes set status bits 4..0
// R14: enabled set status drives event output
// R15: status and enable bit 5 read zero
// R16: input register mirrors pins, upper bits zero
// R17: only routing code 0000 makes input
// R18: write one clears status, set wins
// R19: event output active low while pending
module general_control_event_regs
	import gce_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        arst_n,
	input  wire logic        cfg_read,
	input  wire logic        cfg_write,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [7:0]  cfg_wdata,
	output logic      [7:0]  cfg_rdata,
	input  wire logic        power_change_pulse,
	input  wire logic        prog_12v_change_pulse,
	input  wire logic [4:0]  multipurpose_pins,
	input  wire logic [19:0] pin_route,
	input  wire logic        fm_req,
	input  wire logic        sock_req,
	output logic             fm_gnt,
	output logic             sock_gnt,
	input  wire logic        query_start,
	output logic             query_done,
	output control_t         control,
	output logic             general_event_out_n
);

	localparam int sim_wait = QUERY_SIM_CYCLES + 1;

	logic [7:0]          status;
	logic [7:0]          enable;
	logic [NUM_INPUTS-1:0] levels;
	logic [NUM_INPUTS-1:0] changes;
	logic                wr_lo;
	logic                wr_hi;
	logic                wr_status;
	logic                wr_enable;
	logic                fm_eff;
	arb_state_t          arb_state;
	arb_state_t          next_arb_state;
	logic                last_fm;
	logic [QUERY_W-1:0]  query_cnt;
	logic [15:0]         ctrl_view;

	assign wr_lo     = cfg_write && (cfg_addr == OFS_CTRL_LO);
	assign wr_hi     = cfg_write && (cfg_addr == OFS_CTRL_HI);
	assign wr_status = cfg_write && (cfg_addr == OFS_STATUS);
	assign wr_enable = cfg_write && (cfg_addr == OFS_ENABLE);

	// ************************************************************
	// general control register
	// ************************************************************
	// bus reset is deliberately not an input: only the global reset clears state
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin // R10
			control <= '0;
		end else begin
			if (wr_lo) begin
				control.flash_media_off   <= cfg_wdata[BIT_FM_OFF]; // R7
				control.second_socket_off <= cfg_wdata[BIT_SOCK_OFF]; // R8
				control.upstream_arbitration_policy <= cfg_wdata[BIT_POLICY_LO +: 2]; // R1
			end
			if (wr_hi) begin
				control.fast_query_sim    <= cfg_wdata[BIT_FAST_QUERY - 8]; // R2
				control.io_limit_bit0     <= cfg_wdata[BIT_IO_LIMIT - 8]; // R3
				control.io_base_bit0      <= cfg_wdata[BIT_IO_BASE - 8]; // R4
				control.power_switch_type <= cfg_wdata[BIT_SWITCH_TYPE - 8]; // R5
			end
		end
	end

	always_comb begin
		ctrl_view = CTRL_RESET; // R6 R9
		ctrl_view[BIT_FAST_QUERY]  = control.fast_query_sim;
		ctrl_view[BIT_IO_LIMIT]    = control.io_limit_bit0;
		ctrl_view[BIT_IO_BASE]     = control.io_base_bit0;
		ctrl_view[BIT_SWITCH_TYPE] = control.power_switch_type;
		ctrl_view[BIT_FM_OFF]      = control.flash_media_off;
		ctrl_view[BIT_SOCK_OFF]    = control.second_socket_off;
		ctrl_view[BIT_POLICY_LO +: 2] = control.upstream_arbitration_policy;
	end

	// ************************************************************
	// input pins and change detection
	// ************************************************************
	// index 0..4 carries multipurpose pins 0, 1, 2, 3, 4
	for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_watch
		input_change_watch input_change_watch_i (
			.clock     (clock),
			.arst_n    (arst_n),
			.pin_level (multipurpose_pins[i]),
			.gpi_mode  (pin_route[4*i +: 4] == ROUTE_GPI), // R17
			.level     (levels[i]),
			.change    (changes[i])
		);
	end

	// ************************************************************
	// event status and enable
	// ************************************************************
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			status <= STATUS_RESET;
		end else begin
			// a new event in the clearing cycle survives the clear
			status <= ((status & ~(wr_status ? cfg_wdata : 8'h00)) // R18
				| {power_change_pulse, prog_12v_change_pulse, 1'b0, changes}) // R11 R12 R13
				& EVENT_MASK; // R15
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			enable <= ENABLE_RESET; // R14
		end else if (wr_enable) begin
			enable <= cfg_wdata & EVENT_MASK; // R15
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			general_event_out_n <= 1'b1;
		end else begin
			general_event_out_n <= ~|(status & enable); // R14 R19
		end
	end

	// ************************************************************
	// register read port
	// ************************************************************
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cfg_rdata <= 8'h00;
		end else if (cfg_read) begin
			case (cfg_addr)
				OFS_CTRL_LO: cfg_rdata <= ctrl_view[7:0]; // R6 R9
				OFS_CTRL_HI: cfg_rdata <= ctrl_view[15:8];
				OFS_STATUS:  cfg_rdata <= status;
				OFS_ENABLE:  cfg_rdata <= enable;
				OFS_INPUTS:  cfg_rdata <= {3'h0, levels}; // R16
				default:     cfg_rdata <= 8'h00;
			endcase
		end
	end

	// ************************************************************
	// upstream arbiter
	// ************************************************************
	assign fm_eff   = fm_req & ~control.flash_media_off; // R7
	assign fm_gnt   = (arb_state == ARB_FM);
	assign sock_gnt = (arb_state == ARB_SOCK);

	// reserved code 00 is served as round robin rather than stalling the bus
	always_comb begin
		next_arb_state = arb_state;
		case (arb_state)
			ARB_IDLE: begin
				if (fm_eff && sock_req) begin
					case (control.upstream_arbitration_policy) // R1
						POLICY_FM_FIRST:   next_arb_state = ARB_FM;
						POLICY_SOCK_FIRST: next_arb_state = ARB_SOCK;
						default:           next_arb_state = last_fm ? ARB_SOCK : ARB_FM;
					endcase
				end else if (fm_eff) begin
					next_arb_state = ARB_FM;
				end else if (sock_req) begin
					next_arb_state = ARB_SOCK;
				end
			end
			ARB_FM: begin
				if (!fm_eff) begin
					next_arb_state = ARB_IDLE;
				end
			end
			ARB_SOCK: begin
				if (!sock_req) begin
					next_arb_state = ARB_IDLE;
				end
			end
			default: next_arb_state = ARB_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			arb_state <= ARB_IDLE;
			last_fm   <= 1'b0;
		end else begin
			arb_state <= next_arb_state;
			if (next_arb_state == ARB_FM) begin
				last_fm <= 1'b1;
			end else if (next_arb_state == ARB_SOCK) begin
				last_fm <= 1'b0;
			end
		end
	end

	// ************************************************************
	// card-type query timer
	// ************************************************************
	// a start while a query runs is ignored; the running one completes
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			query_cnt  <= '0;
			query_done <= 1'b0;
		end else begin
			query_done <= (query_cnt == QUERY_W'(1));
			if (query_start && query_cnt == '0) begin
				query_cnt <= control.fast_query_sim ? QUERY_W'(QUERY_SIM_CYCLES) // R2
					: QUERY_W'(QUERY_NORMAL_CYCLES);
			end else if (query_cnt != '0) begin
				query_cnt <= query_cnt - QUERY_W'(1);
			end
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	sequence both_pending;
		arb_state == ARB_IDLE && fm_eff && sock_req;
	endsequence

	sequence short_query_start;
		query_start && query_cnt == '0 && control.fast_query_sim;
	endsequence

	arb_fm_first_a: assert property (@(posedge clock) disable iff (!arst_n) // R1
		both_pending ##0 control.upstream_arbitration_policy == POLICY_FM_FIRST
		|=> fm_gnt && !sock_gnt)
		else $error("flash media priority not honoured");

	arb_sock_first_a: assert property (@(posedge clock) disable iff (!arst_n) // R1
		both_pending ##0 control.upstream_arbitration_policy == POLICY_SOCK_FIRST
		|=> sock_gnt && !fm_gnt)
		else $error("socket priority not honoured");

	query_short_a: assert property (@(posedge clock) disable iff (!arst_n) // R2
		short_query_start |-> ##sim_wait query_done)
		else $error("shortened query did not finish on time");

	io_bits_a: assert property (@(posedge clock) disable iff (!arst_n) // R3 R4
		wr_hi |=> control.io_limit_bit0 == $past(cfg_wdata[BIT_IO_LIMIT - 8])
			&& control.io_base_bit0 == $past(cfg_wdata[BIT_IO_BASE - 8]))
		else $error("I/O bit0 selects not loaded");

	ctrl_read_a: assert property (@(posedge clock) disable iff (!arst_n) // R6 R9
		cfg_read && cfg_addr == OFS_CTRL_LO
		|=> cfg_rdata[BIT_COMPLIANCE] && cfg_rdata[6] == 1'b0 && cfg_rdata[3:2] == 2'h0)
		else $error("fixed control bits read wrong");

	fm_blocked_a: assert property (@(posedge clock) disable iff (!arst_n) // R7
		$past(control.flash_media_off) && control.flash_media_off |-> !fm_gnt)
		else $error("disabled flash media was granted");

	sock_off_a: assert property (@(posedge clock) disable iff (!arst_n) // R8
		wr_lo |=> control.second_socket_off == $past(cfg_wdata[BIT_SOCK_OFF]))
		else $error("second socket disable not loaded");

	power_set_a: assert property (@(posedge clock) disable iff (!arst_n) // R11 R18
		power_change_pulse |=> status[BIT_POWER_CHG])
		else $error("power change event lost");

	prog_set_a: assert property (@(posedge clock) disable iff (!arst_n) // R12 R18
		prog_12v_change_pulse |=> status[BIT_PROG12_CHG])
		else $error("12 V request event lost");

	input_set_a: assert property (@(posedge clock) disable iff (!arst_n) // R13
		changes[0] ##1 1'b1 |-> status[0])
		else $error("input change event lost");

	status_hold_a: assert property (@(posedge clock) disable iff (!arst_n) // R18
		status[BIT_POWER_CHG] && !(wr_status && cfg_wdata[BIT_POWER_CHG])
		|=> status[BIT_POWER_CHG])
		else $error("status bit dropped without a clear");

	event_out_a: assert property (@(posedge clock) disable iff (!arst_n) // R14 R19
		|(status & enable) |=> !general_event_out_n)
		else $error("event output not asserted for enabled status");

	event_idle_a: assert property (@(posedge clock) disable iff (!arst_n) // R14 R19
		!(|(status & enable)) |=> general_event_out_n)
		else $error("event output asserted with nothing pending");

	rsvd_event_a: assert property (@(posedge clock) disable iff (!arst_n) // R15
		!status[BIT_EVT_RSVD] && !enable[BIT_EVT_RSVD])
		else $error("reserved event bit set");

	input_read_a: assert property (@(posedge clock) disable iff (!arst_n) // R16
		cfg_read && cfg_addr == OFS_INPUTS |=> cfg_rdata == {3'h0, $past(levels)})
		else $error("input register read wrong");

endmodule // general_control_event_regs

// [verilog/gce_pkg.sv]
// constants and carrier types for the general control and event register group
package gce_pkg;

	// ************************************************************
	// register offsets (byte addresses in configuration space)
	// ************************************************************
	localparam logic [7:0] OFS_CTRL_LO = 8'h86;
	localparam logic [7:0] OFS_CTRL_HI = 8'h87;
	localparam logic [7:0] OFS_STATUS  = 8'h88;
	localparam logic [7:0] OFS_ENABLE  = 8'h89;
	localparam logic [7:0] OFS_INPUTS  = 8'h8a;

	// ************************************************************
	// general control fields (bit positions within 16 bits)
	// ************************************************************
	localparam int BIT_FAST_QUERY  = 13;
	localparam int BIT_IO_LIMIT    = 12;
	localparam int BIT_IO_BASE     = 11;
	localparam int BIT_SWITCH_TYPE = 10;
	localparam int BIT_COMPLIANCE  = 7;
	localparam int BIT_FM_OFF      = 5;
	localparam int BIT_SOCK_OFF    = 4;
	localparam int BIT_POLICY_LO   = 0;
	localparam logic [15:0] CTRL_RESET = 16'h0080;

	// ************************************************************
	// event status / enable layout
	// ************************************************************
	localparam int BIT_POWER_CHG  = 7;
	localparam int BIT_PROG12_CHG = 6;
	localparam int BIT_EVT_RSVD   = 5;
	localparam logic [7:0] EVENT_MASK   = 8'hdf;
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam int NUM_INPUTS = 5;

	// routing code that selects the general-purpose input function
	localparam logic [3:0] ROUTE_GPI = 4'h0;

	// ************************************************************
	// arbitration codes
	// ************************************************************
	localparam logic [1:0] POLICY_FM_FIRST   = 2'h2;
	localparam logic [1:0] POLICY_SOCK_FIRST = 2'h1;
	localparam logic [1:0] POLICY_ROUND      = 2'h3;

	// ************************************************************
	// card-type query timing at 20 MHz
	// ************************************************************
	localparam int CLOCK_MHZ       = 20;
	localparam int QUERY_NORMAL_US = 100;
	localparam int QUERY_SIM_US    = 1;
	localparam int QUERY_NORMAL_CYCLES = QUERY_NORMAL_US * CLOCK_MHZ;
	localparam int QUERY_SIM_CYCLES    = QUERY_SIM_US * CLOCK_MHZ;
	localparam int QUERY_W = 12;

	typedef enum logic [2:0] {
		ARB_IDLE = 3'b001,
		ARB_FM   = 3'b010,
		ARB_SOCK = 3'b100
	} arb_state_t;

	typedef struct packed {
		logic       fast_query_sim;
		logic       io_limit_bit0;
		logic       io_base_bit0;
		logic       power_switch_type;
		logic       flash_media_off;
		logic       second_socket_off;
		logic [1:0] upstream_arbitration_policy;
	} control_t;

endpackage

// [verilog/input_change_watch.sv]
// level capture and change detection for one multipurpose input pin
`timescale 1ns/1ns
module input_change_watch
	import gce_pkg::*;
(
	input  wire logic clock,
	input  wire logic arst_n,
	input  wire logic pin_level,
	input  wire logic gpi_mode,
	output logic      level,
	output logic      change
);

	logic prev;
	logic primed;

	// prev tracks the raw pin even outside input mode, so entering
	// input mode with a stale history does not fake an event
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			prev   <= 1'b0;
			primed <= 1'b0;
		end else begin
			prev   <= pin_level;
			primed <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			level <= 1'b0;
		end else begin
			level <= gpi_mode & pin_level; // R16 R17
		end
	end

	assign change = primed & gpi_mode & (pin_level != prev); // R13 R17

	no_change_a: assert property (@(posedge clock) disable iff (!arst_n) // R17
		!gpi_mode |-> !change)
		else $error("change flagged on a pin not in input mode");

endmodule // input_change_watch

// [test/system_side_model.sv]
// far-side model: event sources, input pins and upstream requesters
`timescale 1ns/1ns
module system_side_model (
	input  wire logic       clock,
	output logic            power_change_pulse,
	output logic            prog_12v_change_pulse,
	output logic [4:0]      multipurpose_pins,
	output logic            fm_req,
	output logic            sock_req
);
	initial begin
		power_change_pulse = 1'b0;
		prog_12v_change_pulse = 1'b0;
		multipurpose_pins = 5'h00;
		fm_req = 1'b0;
		sock_req = 1'b0;
	end

	// one-cycle software power change: sel 0 supply state, 1 twelve-volt request
	task automatic pulse(input logic sel);
		@(negedge clock);
		prog_12v_change_pulse = sel;
		power_change_pulse = !sel;
		@(negedge clock);
		power_change_pulse = 1'b0;
		prog_12v_change_pulse = 1'b0;
	endtask

	task automatic set_pin(input int idx, input logic val);
		@(negedge clock);
		multipurpose_pins[idx] = val;
	endtask

	// requests are levels, held until withdrawn, as a real requester would
	task automatic request(input logic fm, input logic sock);
		@(negedge clock);
		fm_req = fm;
		sock_req = sock;
	endtask
endmodule // system_side_model

// [test/tb_general_control_event_regs.sv]
// self-checking bench for the general control and event register group
`timescale 1ns/1ns
module tb_general_control_event_regs;
	import gce_pkg::*;
	logic        clock, arst_n, cfg_read, cfg_write, query_start, won_fm;
	logic        power_change_pulse, prog_12v_change_pulse, fm_req, sock_req;
	logic        fm_gnt, sock_gnt, query_done, general_event_out_n;
	logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata;
	logic [4:0]  multipurpose_pins;
	logic [19:0] pin_route;
	control_t    control;
	int          failures = 0;
	int          n_compared = 0;
	int          n, exp;

	general_control_event_regs general_control_event_regs_i (.clock(clock), .arst_n(arst_n),
		.cfg_read(cfg_read), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .power_change_pulse(power_change_pulse),
		.prog_12v_change_pulse(prog_12v_change_pulse), .multipurpose_pins(multipurpose_pins),
		.pin_route(pin_route), .fm_req(fm_req), .sock_req(sock_req), .fm_gnt(fm_gnt),
		.sock_gnt(sock_gnt), .query_start(query_start), .query_done(query_done),
		.control(control), .general_event_out_n(general_event_out_n));

	system_side_model system_side_model_i (.clock(clock),
		.power_change_pulse(power_change_pulse), .prog_12v_change_pulse(prog_12v_change_pulse),
		.multipurpose_pins(multipurpose_pins), .fm_req(fm_req), .sock_req(sock_req));

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// ************************************************************
	// access tasks
	// ************************************************************
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] xp);
		n_compared++;
		if (seen !== xp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, xp, seen);
		end
	endtask

	task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		cfg_write = 1'b1;
		cfg_addr = a;
		cfg_wdata = d;
		@(negedge clock);
		cfg_write = 1'b0;
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] xp);
		@(negedge clock);
		cfg_read = 1'b1;
		cfg_addr = a;
		@(negedge clock);
		cfg_read = 1'b0;
		@(negedge clock);
		check(what, {8'h00, cfg_rdata}, {8'h00, xp});
	endtask

	task automatic idle(input int k);
		repeat (k) @(negedge clock);
	endtask

	task automatic stop_test();
		if (failures == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// whole run needs about 2300 cycles, the query at normal speed dominating
	initial begin
		repeat (10000) @(posedge clock);
		failures++;
		stop_test();
	end

	// ************************************************************
	// stimulus
	// ************************************************************
	initial begin
		arst_n = 1'b0;
		cfg_read = 1'b0;
		cfg_write = 1'b0;
		cfg_addr = 8'h00;
		cfg_wdata = 8'h00;
		query_start = 1'b0;
		pin_route = 20'h0_0000;
		idle(20);
		arst_n = 1'b1;
		idle(2);
		rd_chk("ctrl_lo_reset", OFS_CTRL_LO, 8'h80);
		rd_chk("ctrl_hi_reset", OFS_CTRL_HI, 8'h00);
		rd_chk("enable_reset", OFS_ENABLE, 8'h00);
		rd_chk("status_reset", OFS_STATUS, 8'h00);
		rd_chk("unmapped", 8'h85, 8'h00);
		// all-ones writes expose reserved and read-only positions
		cfg_wr(OFS_CTRL_LO, 8'hff);
		cfg_wr(OFS_CTRL_HI, 8'hff);
		rd_chk("ctrl_lo_ones", OFS_CTRL_LO, 8'hb3);
		rd_chk("ctrl_hi_ones", OFS_CTRL_HI, 8'h3c);
		cfg_wr(OFS_CTRL_HI, 8'h14);
		check("control_a", {8'h00, control}, 16'h005f);
		cfg_wr(OFS_CTRL_HI, 8'h28);
		check("control_b", {8'h00, control}, 16'h00af);
		cfg_wr(OFS_CTRL_LO, 8'h11);
		check("socket_off", {12'h000, control[3:0]}, 16'h0005);
		// policy 00 is included: it must still grant exactly one requester
		for (int p = 0; p < 4; p++) begin
			cfg_wr(OFS_CTRL_LO, 8'(p));
			rd_chk("policy", OFS_CTRL_LO, 8'h80 | 8'(p));
			system_side_model_i.request(1'b1, 1'b1);
			idle(3);
			won_fm = fm_gnt;
			check("one_grant", {15'h0, fm_gnt ^ sock_gnt}, 16'h1);
			// under round robin the socket held the last grant, so flash media is due
			if (p != 0) begin
				check("winner", {14'h0, fm_gnt, sock_gnt}, (p == 1) ? 16'h1 : 16'h2);
			end
			system_side_model_i.request(!won_fm, won_fm);
			idle(4);
			check("second", {14'h0, fm_gnt, sock_gnt}, won_fm ? 16'h1 : 16'h2);
			system_side_model_i.request(1'b0, 1'b0);
			idle(3);
		end
		cfg_wr(OFS_CTRL_LO, 8'h22);
		system_side_model_i.request(1'b1, 1'b0);
		idle(4);
		check("fm_refused", {15'h0, fm_gnt}, 16'h0);
		check("fm_off", {12'h000, control[3:0]}, 16'h000a);
		system_side_model_i.request(1'b0, 1'b0);
		cfg_wr(OFS_CTRL_HI, 8'h20);
		for (int m = 0; m < 2; m++) begin
			@(negedge clock);
			query_start = 1'b1;
			@(negedge clock);
			query_start = 1'b0;
			n = 1;
			while (query_done !== 1'b1 && n < 3000) begin
				@(negedge clock);
				n++;
			end
			exp = m ? QUERY_NORMAL_CYCLES : QUERY_SIM_CYCLES;
			check("query_span", {15'h0, n >= exp && n <= exp + 2}, 16'h1);
			@(negedge clock);
			check("done_pulse", {15'h0, query_done}, 16'h0);
			cfg_wr(OFS_CTRL_HI, 8'h00);
		end
		cfg_wr(OFS_ENABLE, 8'hff);
		rd_chk("enable_rsvd", OFS_ENABLE, EVENT_MASK);
		system_side_model_i.pulse(1'b0);
		idle(3);
		check("event_low", {15'h0, general_event_out_n}, 16'h0);
		rd_chk("power_flag", OFS_STATUS, 8'h80);
		cfg_wr(OFS_STATUS, 8'h7f);
		rd_chk("zero_write", OFS_STATUS, 8'h80);
		fork
			system_side_model_i.pulse(1'b1);
			cfg_wr(OFS_STATUS, 8'hc0);
		join
		rd_chk("set_wins", OFS_STATUS, 8'h40);
		cfg_wr(OFS_STATUS, 8'h40);
		idle(3);
		check("event_high", {15'h0, general_event_out_n}, 16'h1);
		cfg_wr(OFS_ENABLE, 8'h7f);
		system_side_model_i.pulse(1'b0);
		idle(3);
		check("masked", {15'h0, general_event_out_n}, 16'h1);
		cfg_wr(OFS_STATUS, 8'hff);
		for (int i = 0; i < NUM_INPUTS; i++) begin
			system_side_model_i.set_pin(i, 1'b1);
			idle(3);
			rd_chk("pin_flag", OFS_STATUS, 8'(1 << i));
			cfg_wr(OFS_STATUS, 8'hff);
		end
		rd_chk("levels", OFS_INPUTS, 8'h1f);
		// status is cleared after rerouting so only the pin change itself counts
		@(negedge clock);
		pin_route = 20'h0_f000;
		idle(3);
		cfg_wr(OFS_STATUS, 8'hff);
		system_side_model_i.set_pin(3, 1'b0);
		idle(3);
		rd_chk("not_input", OFS_STATUS, 8'h00);
		rd_chk("levels_b", OFS_INPUTS, 8'h17);
		cfg_wr(OFS_CTRL_HI, 8'h3c);
		system_side_model_i.pulse(1'b0);
		@(negedge clock);
		arst_n = 1'b0;
		@(negedge clock);
		check("rst_control", {8'h00, control}, 16'h0000);
		arst_n = 1'b1;
		idle(2);
		rd_chk("rst_hi", OFS_CTRL_HI, 8'h00);
		rd_chk("rst_status", OFS_STATUS, 8'h00);
		rd_chk("rst_lo", OFS_CTRL_LO, 8'h80);
		stop_test();
	end
endmodule // tb_general_control_event_regs
